// >>> rtl/freq_ref_pkg.sv
// Package: register map, reset values, codes and carrier types of the selector
package freq_ref_pkg;

  // **********************************************
  // Register byte addresses
  // **********************************************
  localparam logic [7:0]  ADDR_MAIN_SRC   = 8'h00;
  localparam logic [7:0]  ADDR_AUX_SRC    = 8'h04;
  localparam logic [7:0]  ADDR_AUX_BASIS  = 8'h08;
  localparam logic [7:0]  ADDR_AUX_PCT    = 8'h0C;
  localparam logic [7:0]  ADDR_COMB_SEL   = 8'h10;
  localparam logic [7:0]  ADDR_PRESET     = 8'h14;
  localparam logic [7:0]  ADDR_DIRECTION  = 8'h18;
  localparam logic [7:0]  ADDR_MAX_FREQ   = 8'h1C;
  localparam logic [7:0]  ADDR_OFFSET     = 8'h20;
  localparam logic [7:0]  ADDR_COMM_FREQ  = 8'h24;
  localparam logic [7:0]  ADDR_STEP       = 8'h28;
  localparam logic [7:0]  ADDR_TARGET     = 8'h2C;
  localparam logic [7:0]  ADDR_STATUS     = 8'h30;

  // **********************************************
  // Reset values (frequencies in 0.01 Hz)
  // **********************************************
  localparam logic [15:0] RST_ZERO        = 16'h0000;
  localparam logic [15:0] RST_PRESET      = 16'h1388;
  localparam logic [15:0] RST_MAX_FREQ    = 16'h1388;
  localparam logic [15:0] RST_STEP        = 16'h0001;

  // **********************************************
  // Field layout and limits
  // **********************************************
  localparam int          UNITS_LSB       = 0;
  localparam int          TENS_LSB        = 4;
  localparam logic [15:0] PCT_MAX         = 16'h0096;
  localparam int          PCT_DIV         = 100;
  localparam int          FS_SHIFT        = 14;
  localparam int          STAT_SAME_CHAN  = 0;
  localparam int          STAT_SWITCH     = 1;

  // **********************************************
  // Channel codes
  // **********************************************
  localparam logic [3:0]  SRC_DIG_VOLATILE = 4'h0;
  localparam logic [3:0]  SRC_DIG_RETAIN   = 4'h1;
  localparam logic [3:0]  SRC_ANALOG_ONE   = 4'h2;
  localparam logic [3:0]  SRC_ANALOG_TWO   = 4'h3;
  localparam logic [3:0]  SRC_KEYPAD_POT   = 4'h4;
  localparam logic [3:0]  SRC_PULSE        = 4'h5;
  localparam logic [3:0]  SRC_MULTI_REF    = 4'h6;
  localparam logic [3:0]  SRC_PLC          = 4'h7;
  localparam logic [3:0]  SRC_PID          = 4'h8;
  localparam logic [3:0]  SRC_COMM         = 4'h9;

  // Units digit: how the target is chosen
  localparam logic [3:0]  SEL_MAIN         = 4'h0;
  localparam logic [3:0]  SEL_COMBINED     = 4'h1;
  localparam logic [3:0]  SEL_MAIN_AUX     = 4'h2;
  localparam logic [3:0]  SEL_MAIN_COMB    = 4'h3;
  localparam logic [3:0]  SEL_AUX_COMB     = 4'h4;

  // Tens digit: how main and auxiliary combine
  localparam logic [3:0]  OP_SUM           = 4'h0;
  localparam logic [3:0]  OP_DIFF          = 4'h1;
  localparam logic [3:0]  OP_MAX           = 4'h2;
  localparam logic [3:0]  OP_MIN           = 4'h3;

  localparam logic [3:0]  BASIS_MAX_FREQ   = 4'h0;
  localparam logic [3:0]  BASIS_MAIN       = 4'h1;

  // Signed frequency in 0.01 Hz with headroom for sums
  typedef logic signed [17:0] freq_t;

  // Channel inputs: fractions of full scale (16'h4000 = 100 %) or frequencies
  typedef struct packed {
    logic        [15:0] analog_input_one;
    logic        [15:0] analog_input_two;
    logic        [15:0] keypad_potentiometer_input;
    logic        [15:0] pulse_input_terminal;
    logic        [15:0] multi_reference;
    logic signed [15:0] plc_frequency;
    logic signed [15:0] pid_frequency;
  } chan_in_t;

endpackage : freq_ref_pkg

// >>> rtl/frequency_reference_selector.sv
// Module: target frequency selection, combination, offset and direction
`timescale 1ns/10ps

// What this block does
// RULE_01: Channel code 9 takes the frequency from the host communication register.
// RULE_02: Auxiliary used alone decodes codes 0 to 9 like the main selector.
// RULE_03: Digital auxiliary in superposition ignores preset; up/down adjusts on main.
// RULE_04: Analog or pulse auxiliary in superposition maps full scale to aux range.
// RULE_05: Software should not give main and auxiliary the same channel code.
// RULE_06: Range basis 0 is maximum frequency, 1 is main reference; default 0.
// RULE_07: Auxiliary range is zero to 150 percent of the chosen basis.
// RULE_08: With main basis, auxiliary range follows the main reference continuously.
// RULE_09: Units digit 0 makes main reference the target.
// RULE_10: Units digit 1 makes combined result, chosen by tens digit, the target.
// RULE_11: Units digit 2 picks main, or auxiliary while switch terminal active.
// RULE_12: Units digit 3 picks main, or combined result while switch active.
// RULE_13: Units digit 4 picks auxiliary, or combined result while switch active.
// RULE_14: Tens digit 0 combines as main plus auxiliary.
// RULE_15: Tens digit 1 combines as main minus auxiliary.
// RULE_16: Tens digit 2 picks the reference of larger magnitude.
// RULE_17: Tens digit 3 picks the reference of smaller magnitude.
// RULE_18: Offset frequency is added to every combined result.
// RULE_19: Digital setting starts from the preset, 50.00 Hz after reset.
// RULE_20: Direction code 1 inverts commanded rotation, code 0 keeps it.
// RULE_21: Analog, pulse and multi-reference main inputs map full scale to max.
// RULE_22: Target is re-evaluated every clock, so switch changes act next cycle.
module frequency_reference_selector
  import freq_ref_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire chan_in_t    chan_in,
  input  wire logic        freq_switch,
  input  wire logic        up_pulse,
  input  wire logic        down_pulse,
  output freq_t            target_freq,
  output logic             reverse_rotation
);

  // **********************************************
  // Arithmetic helpers
  // **********************************************

  // Magnitude of a signed frequency
  function automatic freq_t abs_f(input freq_t f);
    abs_f = f[17] ? -f : f;
  endfunction : abs_f

  // Fraction of full scale times a base frequency
  function automatic freq_t scale_fs(input logic [15:0] v, input freq_t base);
    logic signed [35:0] p;
    p = $signed({2'b00, v}) * base;
    scale_fs = freq_t'(p >>> FS_SHIFT);
  endfunction : scale_fs

  // Clamp to plus or minus the maximum frequency
  function automatic freq_t clamp_f(input freq_t f, input freq_t lim);
    if (f > lim)
      clamp_f = lim;
    else if (f < -lim)
      clamp_f = -lim;
    else
      clamp_f = f;
  endfunction : clamp_f

  // Frequency of a channel; fractional inputs scale against fs_base
  function automatic freq_t chan_freq(input logic [3:0] code, input freq_t digital,
                                      input freq_t fs_base, input chan_in_t ci,
                                      input freq_t comm);
    case (code)
      SRC_DIG_VOLATILE,
      SRC_DIG_RETAIN:   chan_freq = digital;
      SRC_ANALOG_ONE:   chan_freq = scale_fs(ci.analog_input_one, fs_base);
      SRC_ANALOG_TWO:   chan_freq = scale_fs(ci.analog_input_two, fs_base);
      SRC_KEYPAD_POT:   chan_freq = scale_fs(ci.keypad_potentiometer_input, fs_base);
      SRC_PULSE:        chan_freq = scale_fs(ci.pulse_input_terminal, fs_base);
      SRC_MULTI_REF:    chan_freq = scale_fs(ci.multi_reference, fs_base);
      SRC_PLC:          chan_freq = freq_t'(ci.plc_frequency);
      SRC_PID:          chan_freq = freq_t'(ci.pid_frequency);
      SRC_COMM:         chan_freq = comm;                       // [RULE_01]
      default:          chan_freq = digital;
    endcase
  endfunction : chan_freq

  // **********************************************
  // Registers
  // **********************************************
  logic [15:0] main_src_ff;
  logic [15:0] aux_src_ff;
  logic [15:0] aux_basis_ff;
  logic [15:0] aux_pct_ff;
  logic [15:0] comb_sel_ff;
  logic [15:0] preset_ff;
  logic [15:0] direction_ff;
  logic [15:0] max_freq_ff;
  logic [15:0] offset_ff;
  logic [15:0] comm_freq_ff;
  logic [15:0] step_ff;
  freq_t       updown_ff;
  freq_t       target_ff;
  logic        reverse_ff;
  logic [31:0] prdata_ff;

  logic        wr_en;
  logic        setup;
  logic        mapped;
  logic [15:0] wdata16;
  logic [31:0] nxt_prdata;
  freq_t       nxt_updown;
  freq_t       nxt_target;

  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite & mapped;
  assign wdata16 = pwdata[15:0];

  // Address decode over the mapped words
  always_comb
  begin
    case (paddr)
      ADDR_MAIN_SRC, ADDR_AUX_SRC, ADDR_AUX_BASIS, ADDR_AUX_PCT,
      ADDR_COMB_SEL, ADDR_PRESET, ADDR_DIRECTION, ADDR_MAX_FREQ,
      ADDR_OFFSET, ADDR_COMM_FREQ, ADDR_STEP,
      ADDR_TARGET, ADDR_STATUS: mapped = 1'b1;
      default:                  mapped = 1'b0;
    endcase
  end

  // Zero wait states; unmapped access answers with an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata  = prdata_ff;

  // Software-written configuration
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      main_src_ff  <= RST_ZERO;
      aux_src_ff   <= RST_ZERO;
      aux_basis_ff <= RST_ZERO;                                // [RULE_06]
      aux_pct_ff   <= RST_ZERO;
      comb_sel_ff  <= RST_ZERO;
      preset_ff    <= RST_PRESET;                              // [RULE_19]
      direction_ff <= RST_ZERO;
      max_freq_ff  <= RST_MAX_FREQ;
      offset_ff    <= RST_ZERO;
      comm_freq_ff <= RST_ZERO;
      step_ff      <= RST_STEP;
    end
    else if (wr_en)
    begin
      case (paddr)
        ADDR_MAIN_SRC:  main_src_ff  <= wdata16;
        ADDR_AUX_SRC:   aux_src_ff   <= wdata16;
        ADDR_AUX_BASIS: aux_basis_ff <= wdata16;
        ADDR_AUX_PCT:   aux_pct_ff   <= (wdata16 > PCT_MAX) ? PCT_MAX : wdata16; // [RULE_07]
        ADDR_COMB_SEL:  comb_sel_ff  <= wdata16;
        ADDR_PRESET:    preset_ff    <= wdata16;
        ADDR_DIRECTION: direction_ff <= wdata16;
        ADDR_MAX_FREQ:  max_freq_ff  <= wdata16;
        ADDR_OFFSET:    offset_ff    <= wdata16;
        ADDR_COMM_FREQ: comm_freq_ff <= wdata16;
        ADDR_STEP:      step_ff      <= wdata16;
        default:        step_ff      <= step_ff;
      endcase
    end
  end

  // **********************************************
  // Reference computation
  // **********************************************
  freq_t       max_f;
  freq_t       preset_f;
  freq_t       offset_f;
  freq_t       comm_f;
  freq_t       digital_f;
  freq_t       main_f;
  freq_t       aux_alone_f;
  freq_t       aux_sup_f;
  freq_t       basis_f;
  freq_t       range_f;
  freq_t       comb_f;
  logic [3:0]  units;
  logic [3:0]  tens;
  logic signed [35:0] range_p;

  assign max_f     = freq_t'($signed({2'b00, max_freq_ff}));
  assign preset_f  = freq_t'($signed({2'b00, preset_ff}));
  assign offset_f  = freq_t'($signed(offset_ff));
  assign comm_f    = freq_t'($signed(comm_freq_ff));
  assign units     = comb_sel_ff[UNITS_LSB +: 4];
  assign tens      = comb_sel_ff[TENS_LSB +: 4];

  // Digital setting starts at preset and moves with up/down
  assign digital_f = preset_f + updown_ff;                     // [RULE_19]

  // Main reference; fractional channels scale to maximum frequency
  assign main_f = chan_freq(main_src_ff[3:0], digital_f, max_f, chan_in, comm_f); // [RULE_21]

  // Auxiliary used alone decodes exactly like main
  assign aux_alone_f = chan_freq(aux_src_ff[3:0], digital_f, max_f, chan_in,
                                 comm_f);                      // [RULE_02]

  // Range basis tracks main every cycle when selected
  assign basis_f = (aux_basis_ff[3:0] == BASIS_MAIN) ? abs_f(main_f)   // [RULE_08]
                                                     : max_f;          // [RULE_06]
  assign range_p = (basis_f * $signed({2'b00, aux_pct_ff})) / PCT_DIV;          // [RULE_07]
  assign range_f = freq_t'(range_p);

  // Auxiliary in superposition: digital adjusts on main, fractional channels scale to range, PLC, PID and host pass unscaled
  always_comb
  begin
    case (aux_src_ff[3:0])
      SRC_DIG_VOLATILE,
      SRC_DIG_RETAIN: aux_sup_f = updown_ff;                   // [RULE_03]
      default:        aux_sup_f = chan_freq(aux_src_ff[3:0], digital_f, range_f,
                                            chan_in, comm_f);  // [RULE_04]
    endcase
  end

  // Combination of main and auxiliary plus offset
  always_comb
  begin
    case (tens)
      OP_SUM:  comb_f = main_f + aux_sup_f;                    // [RULE_14]
      OP_DIFF: comb_f = main_f - aux_sup_f;                    // [RULE_15]
      OP_MAX:  comb_f = (abs_f(main_f) >= abs_f(aux_sup_f)) ? main_f : aux_sup_f; // [RULE_16]
      OP_MIN:  comb_f = (abs_f(main_f) <= abs_f(aux_sup_f)) ? main_f : aux_sup_f; // [RULE_17]
      default: comb_f = main_f + aux_sup_f;
    endcase
    comb_f = comb_f + offset_f;                                // [RULE_18]
  end

  // Target selection by units digit and switch terminal
  always_comb
  begin
    case (units)
      SEL_MAIN:      nxt_target = main_f;                                   // [RULE_09]
      SEL_COMBINED:  nxt_target = comb_f;                                   // [RULE_10]
      SEL_MAIN_AUX:  nxt_target = freq_switch ? aux_alone_f : main_f;       // [RULE_11]
      SEL_MAIN_COMB: nxt_target = freq_switch ? comb_f : main_f;            // [RULE_12]
      SEL_AUX_COMB:  nxt_target = freq_switch ? comb_f : aux_alone_f;       // [RULE_13]
      default:       nxt_target = main_f;
    endcase
    nxt_target = clamp_f(nxt_target, max_f);
  end

  // Target and direction refreshed every clock
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      target_ff  <= '0;
      reverse_ff <= 1'b0;
    end
    else
    begin
      target_ff  <= nxt_target;                                // [RULE_22]
      reverse_ff <= (direction_ff[3:0] == 4'h1);               // [RULE_20]
    end
  end

  assign target_freq      = target_ff;
  assign reverse_rotation = reverse_ff;

  // **********************************************
  // Up/down adjustment
  // **********************************************

  // Step adds or subtracts; both at once cancel; kept within max
  always_comb
  begin
    nxt_updown = updown_ff;
    if (up_pulse && !down_pulse)
      nxt_updown = updown_ff + freq_t'($signed({2'b00, step_ff}));
    else if (down_pulse && !up_pulse)
      nxt_updown = updown_ff - freq_t'($signed({2'b00, step_ff}));
    nxt_updown = clamp_f(nxt_updown, max_f);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      updown_ff <= '0;
    else
      updown_ff <= nxt_updown;
  end

  // **********************************************
  // Read path
  // **********************************************

  // Read data captured in the setup phase
  always_comb
  begin
    nxt_prdata = 32'h0000_0000;
    case (paddr)
      ADDR_MAIN_SRC:  nxt_prdata[15:0] = main_src_ff;
      ADDR_AUX_SRC:   nxt_prdata[15:0] = aux_src_ff;
      ADDR_AUX_BASIS: nxt_prdata[15:0] = aux_basis_ff;
      ADDR_AUX_PCT:   nxt_prdata[15:0] = aux_pct_ff;
      ADDR_COMB_SEL:  nxt_prdata[15:0] = comb_sel_ff;
      ADDR_PRESET:    nxt_prdata[15:0] = preset_ff;
      ADDR_DIRECTION: nxt_prdata[15:0] = direction_ff;
      ADDR_MAX_FREQ:  nxt_prdata[15:0] = max_freq_ff;
      ADDR_OFFSET:    nxt_prdata[15:0] = offset_ff;
      ADDR_COMM_FREQ: nxt_prdata[15:0] = comm_freq_ff;
      ADDR_STEP:      nxt_prdata[15:0] = step_ff;
      ADDR_TARGET:    nxt_prdata[15:0] = target_ff[15:0];
      ADDR_STATUS:
      begin
        // Same-channel warning for the configuring side
        nxt_prdata[STAT_SAME_CHAN] = (main_src_ff == aux_src_ff); // [RULE_05]
        nxt_prdata[STAT_SWITCH]    = freq_switch;
      end
      default:        nxt_prdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_ff <= 32'h0000_0000;
    else if (setup && !pwrite)
      prdata_ff <= nxt_prdata;
  end

endmodule : frequency_reference_selector

// >>> dv/freq_ref_checker.sv
// Checker: bus and target frequency properties of the selector
`timescale 1ns/10ps
module freq_ref_checker
  import freq_ref_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire freq_t       target_freq,
  input wire logic        reverse_rotation
);
  // ***********************************
  // Shadow copies of written registers
  // ***********************************
  logic [15:0] main_ff, comb_ff, pct_ff, preset_ff, dir_ff, comm_ff, max_ff;
  logic        comm_sel;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Track completed writes to the shadowed registers that the selector keeps
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      {main_ff, comb_ff, pct_ff, dir_ff, comm_ff} <= '0;
      preset_ff <= RST_PRESET;
      max_ff    <= RST_MAX_FREQ;
    end
    else if (psel && penable && pwrite && pready)
    begin
      case (paddr)
        ADDR_MAIN_SRC:  main_ff   <= pwdata[15:0];
        ADDR_COMB_SEL:  comb_ff   <= pwdata[15:0];
        ADDR_AUX_PCT:   pct_ff    <= (pwdata[15:0] > PCT_MAX) ? PCT_MAX : pwdata[15:0];
        ADDR_PRESET:    preset_ff <= pwdata[15:0];
        ADDR_DIRECTION: dir_ff    <= pwdata[15:0];
        ADDR_COMM_FREQ: comm_ff   <= pwdata[15:0];
        ADDR_MAX_FREQ:  max_ff    <= pwdata[15:0];
        default: ;
      endcase
    end

  // Main channel is the host register and the units digit picks main
  assign comm_sel = (main_ff[3:0] == SRC_COMM) && (comb_ff[3:0] == SEL_MAIN);

  property rd_back(a, v);
    psel && penable && !pwrite && paddr == a |-> prdata == {16'h0000, v};
  endproperty

  ready_always_a: assert property (psel |-> pready)
    else $error("pready low during a transfer");
  unmapped_err_a: assert property (psel && penable |-> pslverr == (paddr > ADDR_STATUS))
    else $error("pslverr does not match address decode");
  unmapped_zero_a: assert property (psel && penable && !pwrite && paddr > ADDR_STATUS
    |-> prdata == 32'h0000_0000) else $error("unmapped read not zero");
  pct_back_a: assert property (rd_back(ADDR_AUX_PCT, pct_ff))
    else $error("percent readback wrong");
  preset_back_a: assert property (rd_back(ADDR_PRESET, preset_ff))
    else $error("preset readback wrong");
  comm_target_a: assert property (comm_sel && $past(comm_sel)
    |-> target_freq == freq_t'($signed($past(comm_ff)))) else $error("target not host value");
  dir_follow_a: assert property ($stable(dir_ff)
    |-> reverse_rotation == (dir_ff[3:0] == 4'h1)) else $error("direction output wrong");
  target_bound_a: assert property ($stable(max_ff) |-> target_freq <= $signed({2'b00, max_ff})
    && target_freq >= -$signed({2'b00, max_ff})) else $error("target beyond maximum");

  cover property (psel && penable && pslverr);
  cover property ($rose(reverse_rotation));
  cover property (comm_sel && $past(comm_sel));
endmodule : freq_ref_checker

bind frequency_reference_selector freq_ref_checker chk_u (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .target_freq(target_freq),
  .reverse_rotation(reverse_rotation));

// >>> dv/freq_ref_panel.sv
// Partner: channel inputs, switch terminal and up/down keys
`timescale 1ns/10ps
module freq_ref_panel
  import freq_ref_pkg::*;
(
  input  wire logic pclk,
  output chan_in_t  chan_in,
  output logic      freq_switch,
  output logic      up_pulse,
  output logic      down_pulse
);
  // Idle terminals, zero analog inputs and fixed low levels on the other channels at time zero
  initial
  begin
    chan_in     = '{16'h0000, 16'h0000, 16'h1000, 16'h0800, 16'h0400, 16'sh0100, 16'sh0200};
    freq_switch = 1'b0;
    up_pulse    = 1'b0;
    down_pulse  = 1'b0;
  end

  // Analog levels change right after an edge
  task automatic set_analog(input logic [15:0] one, input logic [15:0] two);
    @(posedge pclk);
    chan_in.analog_input_one <= one;
    chan_in.analog_input_two <= two;
  endtask : set_analog

  task automatic set_switch(input logic v);
    @(posedge pclk);
    freq_switch <= v;
  endtask : set_switch

  // One-cycle key pulses with a gap between them
  task automatic press(input logic up, input int n);
    repeat (n)
    begin
      @(posedge pclk);
      up_pulse   <= up;
      down_pulse <= !up;
      @(posedge pclk);
      up_pulse   <= 1'b0;
      down_pulse <= 1'b0;
    end
  endtask : press
endmodule : freq_ref_panel

// >>> dv/tb_frequency_reference_selector.sv
// Testbench: register access and target selection of the selector
`timescale 1ns/10ps
module tb_frequency_reference_selector
  import freq_ref_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        freq_switch, up_pulse, down_pulse, reverse_rotation;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  chan_in_t    chan_in;
  freq_t       target_freq;
  int          errors, n_compared;
  int          ops_exp[4] = '{4600, 600, 2600, 2100};
  int          sw_exp[3][2] = '{'{2500, 5000}, '{2500, 4600}, '{5000, 4600}};
  int          code_exp[5] = '{1250, 625, 312, 256, 512};
  logic [7:0]  rst_addr[6] = '{ADDR_AUX_SRC, ADDR_AUX_BASIS, ADDR_AUX_PCT, ADDR_COMB_SEL,
                               ADDR_PRESET, ADDR_DIRECTION};
  logic [15:0] rst_val[6] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, RST_PRESET, 16'h0000};
  logic [31:0] q;
  logic        e;

  frequency_reference_selector dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .chan_in(chan_in), .freq_switch(freq_switch),
    .up_pulse(up_pulse), .down_pulse(down_pulse), .target_freq(target_freq),
    .reverse_rotation(reverse_rotation));

  freq_ref_panel panel_u (.pclk(pclk), .chan_in(chan_in), .freq_switch(freq_switch),
    .up_pulse(up_pulse), .down_pulse(down_pulse));

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  task automatic complete_run();
    if (errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
      errors++;
    end
  endtask : check

  // One transfer: setup, then access held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic err);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      errors++;
      complete_run();
    end
    rq = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rd(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, q, e);
    check(name, q, exp);
  endtask : rd

  // Target has settled once the inputs have been still for a few edges
  task automatic tgt(input int exp);
    repeat (3) @(posedge pclk);
    check("target", 32'(target_freq), exp);
  endtask : tgt

  // Main sequence
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    errors = 0;
    n_compared = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rst_addr[i]) rd("reset value", rst_addr[i], {16'h0000, rst_val[i]});
    tgt(5000);
    apb(1'b0, 8'h40, 32'h0000_0000, q, e);
    check("unmapped error", {31'h0, e}, 32'h1);
    check("unmapped data", q, 32'h0);
    wr(ADDR_AUX_PCT, 32'd200);
    rd("percent clamp", ADDR_AUX_PCT, 32'd150);
    wr(ADDR_COMM_FREQ, 32'd1234);
    wr(ADDR_MAIN_SRC, {28'h0, SRC_COMM});
    tgt(1234);
    for (int d = 1; d >= 0; d--)
    begin
      wr(ADDR_DIRECTION, 32'(d));
      repeat (2) @(posedge pclk);
      check("reverse", {31'h0, reverse_rotation}, 32'(d));
    end
    panel_u.set_analog(16'h2000, 16'h4000);
    wr(ADDR_MAIN_SRC, {28'h0, SRC_ANALOG_ONE});
    wr(ADDR_AUX_SRC, {28'h0, SRC_ANALOG_TWO});
    wr(ADDR_AUX_PCT, 32'd40);
    wr(ADDR_OFFSET, 32'd100);
    tgt(2500);
    for (int op = 0; op < 4; op++)
    begin
      wr(ADDR_COMB_SEL, 32'((op << TENS_LSB) | 1));
      tgt(ops_exp[op]);
    end
    for (int u = 0; u < 3; u++)
    begin
      wr(ADDR_COMB_SEL, 32'(u + 2));
      for (int s = 0; s < 2; s++)
      begin
        panel_u.set_switch(s[0]);
        @(posedge pclk);
        #1;
        check("switch", 32'(target_freq), sw_exp[u][s]);
      end
    end
    panel_u.set_switch(1'b0);
    wr(ADDR_COMB_SEL, 32'h1);
    wr(ADDR_AUX_BASIS, {28'h0, BASIS_MAIN});
    tgt(3600);
    panel_u.set_analog(16'h1000, 16'h4000);
    tgt(1850);
    wr(ADDR_AUX_BASIS, {28'h0, BASIS_MAX_FREQ});
    wr(ADDR_AUX_SRC, {28'h0, SRC_DIG_VOLATILE});
    wr(ADDR_STEP, 32'd100);
    panel_u.set_analog(16'h2000, 16'h4000);
    panel_u.press(1'b1, 4);
    panel_u.press(1'b0, 1);
    tgt(2900);
    // Remaining main channel codes: keypad, pulse, multi-reference, PLC, PID
    wr(ADDR_COMB_SEL, 32'h0);
    for (int c = 0; c < 5; c++)
    begin
      wr(ADDR_MAIN_SRC, 32'(c + 4));
      tgt(code_exp[c]);
    end
    // Auxiliary alone on the host channel, status and target readback
    wr(ADDR_AUX_SRC, {28'h0, SRC_COMM});
    wr(ADDR_COMB_SEL, 32'h2);
    panel_u.set_switch(1'b1);
    tgt(1234);
    rd("status", ADDR_STATUS, 32'h2);
    rd("target readback", ADDR_TARGET, 32'd1234);
    // Digital main starts from a rewritten preset plus the up/down offset
    wr(ADDR_PRESET, 32'd3000);
    wr(ADDR_MAIN_SRC, {28'h0, SRC_DIG_RETAIN});
    panel_u.set_switch(1'b0);
    tgt(3300);
    complete_run();
  end
endmodule : tb_frequency_reference_selector
